// ---- irc_pkg.sv ----
// Package for the infrared remote carrier and data-bit waveform unit.
// Assumes a single 20 MHz core clock and an AHB-Lite register bus.
package irc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] IRC_OFS_CLOCK_SETUP = 8'h00;
   localparam logic [7:0] IRC_OFS_CONTROL     = 8'h04;
   localparam logic [7:0] IRC_OFS_BIT_COUNT   = 8'h08;
   localparam logic [7:0] IRC_OFS_ACTIVE_LEN  = 8'h0C;
   localparam logic [7:0] IRC_OFS_BIT_LEN     = 8'h10;
   localparam logic [7:0] IRC_OFS_CARRIER     = 8'h14;
   localparam logic [7:0] IRC_OFS_FLAGS       = 8'h18;
   localparam logic [7:0] IRC_OFS_ENABLES     = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int          IRC_CLK_KEEP_BIT   = 8;
   localparam int          IRC_CLK_DIV_LSB    = 4;
   localparam int          IRC_CLK_SRC_LSB    = 0;
   localparam int          IRC_FLAG_ACT_BIT   = 0;
   localparam int          IRC_FLAG_LEN_BIT   = 1;
   localparam int          IRC_FLAG_APEND_BIT = 2;
   localparam int          IRC_FLAG_LPEND_BIT = 3;
   localparam logic [15:0] IRC_LEN_RESET      = 16'h0000;
   localparam logic [7:0]  IRC_CARR_RESET     = 8'h00;
   localparam logic [14:0] IRC_PRESC_RESET    = 15'h0000;

   // Software-visible control word of the counter control register.
   typedef struct packed {
      logic [5:0] rsv_hi;
      logic       counter_clear;
      logic       count_run;
      logic [2:0] rsv_mid;
      logic       output_invert;
      logic       compare_buffer_enable;
      logic       oneshot_select;
      logic       unit_soft_reset;
      logic       unit_enable;
   } irc_ctrl_t;

   // Carrier settings word: period in the high byte, duty in the low byte.
   typedef struct packed {
      logic [7:0] carrier_period;
      logic [7:0] carrier_duty;
   } irc_carrier_t;

   // Unit clock setup word.
   typedef struct packed {
      logic       debug_clock_keep;
      logic [3:0] clock_divider;
      logic [1:0] clock_source;
   } irc_clk_t;

endpackage : irc_pkg

// ---- irc_unit.sv ----
// Infrared remote waveform unit: carrier counter, data-bit counter, match flags.
// Assumes a 20 MHz core clock, one AHB-Lite master and synchronous inputs.
// Behaviour
// - Transmit pin is carrier AND data.
// - Carrier from 8-bit counter on unit clock.
// - Duty match toggles carrier; duty below period.
// - Period match toggles carrier, counter to zero.
// - Clear and run control both counters together.
// - Data signal from 16-bit counter and lengths.
// - Active-length match toggles data signal.
// - Bit-length match toggles data, counter zero.
// - Repeat mode counts until run cleared.
// - One-shot mode stops at bit-length match.
// - Unbuffered compares use fields directly, immediately.
// - Buffered compares use shadow copies.
// - Shadows load at bit-length shadow match.
// - Pending flags set on write, cleared on transfer.
// - Active-match flag set on active match.
// - Length-match flag set on length match.
// - Match flags cleared by one or reset.
// - Interrupt only when flag and enable set.
// - Pins driven only while run is one; irq is not.
// - Clear pulse high between active and length matches.
// - Bit 8 keeps unit clock in debug.
// - Divider field 2^-n, source field two bits.
// - Invert bit; data active from counter zero.
// - Clear reads one until clearing finishes.
// - Soft reset clears counters, match flags, then itself.
`timescale 1ns/1ps
`default_nettype none
module irc_unit
   import irc_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Processor state.
   input  wire logic        debug_mode,
   // Pins and interrupt.
   output logic             ir_transmit_output,
   output logic             clear_pulse_output,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   irc_clk_t     clk_setup_reg;
   irc_ctrl_t    ctrl_reg;
   irc_carrier_t carrier_reg;
   logic [15:0]  active_len_reg;
   logic [15:0]  bit_len_reg;
   logic [15:0]  active_shadow_reg;
   logic [15:0]  bit_shadow_reg;
   logic [15:0]  bit_cnt_reg;
   logic [7:0]   carr_cnt_reg;
   logic [14:0]  presc_reg;
   logic         carrier_sig_reg;
   logic         data_sig_reg;
   logic         active_flag_reg;
   logic         length_flag_reg;
   logic         active_pend_reg;
   logic         length_pend_reg;
   logic         active_ie_reg;
   logic         length_ie_reg;
   logic         wr_pend_reg;
   logic         rd_pend_reg;
   logic [7:0]   addr_reg;
   logic [31:0]  hrdata_reg;
   logic         hreadyout_reg;
   logic         tx_reg;
   logic         clp_reg;
   logic         irq_reg;

   logic         wr_en;
   logic         wr_clk;
   logic         wr_ctrl;
   logic         wr_alen;
   logic         wr_blen;
   logic         wr_flags;
   logic         tick;
   logic         running;
   logic [14:0]  div_mask;
   logic [15:0]  ap_cmp;
   logic [15:0]  db_cmp;
   logic         ap_hit;
   logic         db_hit;
   logic         srst;
   logic         tx_next;
   logic         clp_next;
   logic [31:0]  rd_next;

   // ----------------------------------------------------------------
   // AHB-Lite slave: writes land in the data phase, reads take one wait.
   // ----------------------------------------------------------------

   // Address phase capture and the read wait state.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_pend_reg   <= 1'b0;
         rd_pend_reg   <= 1'b0;
         addr_reg      <= 8'h00;
         hreadyout_reg <= 1'b1;
         hrdata_reg    <= 32'h0000_0000;
      end
      else if (rd_pend_reg)
      begin
         rd_pend_reg   <= 1'b0;
         hreadyout_reg <= 1'b1;
         hrdata_reg    <= rd_next;
      end
      else if (hready)
      begin
         wr_pend_reg   <= hsel && htrans[1] && hwrite;
         rd_pend_reg   <= hsel && htrans[1] && !hwrite;
         hreadyout_reg <= !(hsel && htrans[1] && !hwrite);
         addr_reg      <= haddr;
      end
      else
      begin
         wr_pend_reg <= 1'b0;
      end
   end

   // Write strobes per register.
   assign wr_en    = wr_pend_reg;
   assign wr_clk   = wr_en && (addr_reg == IRC_OFS_CLOCK_SETUP) && !ctrl_reg.unit_enable;
   assign wr_ctrl  = wr_en && (addr_reg == IRC_OFS_CONTROL);
   assign wr_alen  = wr_en && (addr_reg == IRC_OFS_ACTIVE_LEN) && ctrl_reg.unit_enable;
   assign wr_blen  = wr_en && (addr_reg == IRC_OFS_BIT_LEN) && ctrl_reg.unit_enable;
   assign wr_flags = wr_en && (addr_reg == IRC_OFS_FLAGS);
   assign srst     = ctrl_reg.unit_soft_reset;

   // Read mux; unmapped offsets and reserved bits read zero.
   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (addr_reg)
         IRC_OFS_CLOCK_SETUP: rd_next[8:0] = {clk_setup_reg.debug_clock_keep, clk_setup_reg.clock_divider,
                                              2'b00, clk_setup_reg.clock_source};
         IRC_OFS_CONTROL:     rd_next[15:0] = {6'h00, ctrl_reg.counter_clear, ctrl_reg.count_run, 3'h0,
                                               ctrl_reg.output_invert, ctrl_reg.compare_buffer_enable,
                                               ctrl_reg.oneshot_select, ctrl_reg.unit_soft_reset,
                                               ctrl_reg.unit_enable};
         IRC_OFS_BIT_COUNT:   rd_next[15:0] = bit_cnt_reg;
         IRC_OFS_ACTIVE_LEN:  rd_next[15:0] = active_len_reg;
         IRC_OFS_BIT_LEN:     rd_next[15:0] = bit_len_reg;
         IRC_OFS_CARRIER:     rd_next[15:0] = carrier_reg;
         IRC_OFS_FLAGS:       rd_next[3:0] = {length_pend_reg, active_pend_reg, length_flag_reg, active_flag_reg};
         IRC_OFS_ENABLES:     rd_next[1:0] = {length_ie_reg, active_ie_reg};
         default:             rd_next = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------

   // Clock setup, alterable only while the unit is disabled.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         clk_setup_reg <= '0;
      else if (wr_clk)
      begin
         clk_setup_reg.debug_clock_keep <= hwdata[IRC_CLK_KEEP_BIT];
         clk_setup_reg.clock_divider    <= hwdata[IRC_CLK_DIV_LSB +: 4];
         clk_setup_reg.clock_source     <= hwdata[IRC_CLK_SRC_LSB +: 2];
      end
   end

   // Carrier settings, interrupt enables and length fields.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         carrier_reg    <= {IRC_CARR_RESET, IRC_CARR_RESET};
         active_len_reg <= IRC_LEN_RESET;
         bit_len_reg    <= IRC_LEN_RESET;
         active_ie_reg  <= 1'b0;
         length_ie_reg  <= 1'b0;
      end
      else
      begin
         if (wr_en && addr_reg == IRC_OFS_CARRIER)
            carrier_reg <= hwdata[15:0];
         if (wr_en && addr_reg == IRC_OFS_ENABLES)
         begin
            active_ie_reg <= hwdata[IRC_FLAG_ACT_BIT];
            length_ie_reg <= hwdata[IRC_FLAG_LEN_BIT];
         end
         if (wr_alen)
            active_len_reg <= hwdata[15:0];
         if (wr_blen)
            bit_len_reg <= hwdata[15:0];
      end
   end

   // Counter control: soft reset lasts one cycle, clear lasts until a tick.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ctrl_reg <= '0;
      else if (srst)
      begin
         ctrl_reg.unit_soft_reset <= 1'b0;
         ctrl_reg.counter_clear   <= 1'b0;
         ctrl_reg.count_run       <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         ctrl_reg.unit_enable           <= hwdata[0];
         ctrl_reg.unit_soft_reset       <= hwdata[1];
         ctrl_reg.oneshot_select        <= hwdata[2];
         ctrl_reg.compare_buffer_enable <= hwdata[3];
         ctrl_reg.output_invert         <= hwdata[4];
         ctrl_reg.count_run             <= hwdata[8];
         ctrl_reg.counter_clear         <= hwdata[9] | (ctrl_reg.counter_clear & !tick);
      end
      else
      begin
         if (db_hit && ctrl_reg.oneshot_select)
            ctrl_reg.count_run <= 1'b0;
         if (tick)
            ctrl_reg.counter_clear <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Unit clock enable from the binary divider.
   // ----------------------------------------------------------------

   // Prescaler runs while enabled and not halted by debug.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         presc_reg <= IRC_PRESC_RESET;
      else if (!ctrl_reg.unit_enable)
         presc_reg <= IRC_PRESC_RESET;
      else if (!debug_mode || clk_setup_reg.debug_clock_keep)
         presc_reg <= presc_reg + 15'h0001;
   end

   // One tick every 2^n core cycles.
   assign div_mask = 15'((16'h0001 << clk_setup_reg.clock_divider) - 16'h0001);
   assign tick     = ctrl_reg.unit_enable && (!debug_mode || clk_setup_reg.debug_clock_keep)
                     && ((presc_reg & div_mask) == div_mask);
   assign running  = ctrl_reg.count_run && !ctrl_reg.counter_clear && !srst;

   // ----------------------------------------------------------------
   // Compare values and matches.
   // ----------------------------------------------------------------
   assign ap_cmp = ctrl_reg.compare_buffer_enable ? active_shadow_reg : active_len_reg;
   assign db_cmp = ctrl_reg.compare_buffer_enable ? bit_shadow_reg : bit_len_reg;
   assign ap_hit = tick && running && (bit_cnt_reg == ap_cmp);
   assign db_hit = tick && running && (bit_cnt_reg == db_cmp);

   // Shadows follow the fields while unbuffered and load at each bit end.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active_shadow_reg <= IRC_LEN_RESET;
         bit_shadow_reg    <= IRC_LEN_RESET;
      end
      else if (!ctrl_reg.compare_buffer_enable || db_hit)
      begin
         active_shadow_reg <= active_len_reg;
         bit_shadow_reg    <= bit_len_reg;
      end
   end

   // Pending flags: a write in the transfer cycle keeps the flag set.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active_pend_reg <= 1'b0;
         length_pend_reg <= 1'b0;
      end
      else if (!ctrl_reg.compare_buffer_enable)
      begin
         active_pend_reg <= 1'b0;
         length_pend_reg <= 1'b0;
      end
      else
      begin
         active_pend_reg <= wr_alen | (active_pend_reg & !db_hit);
         length_pend_reg <= wr_blen | (length_pend_reg & !db_hit);
      end
   end

   // ----------------------------------------------------------------
   // Data-bit and carrier counters with their waveforms.
   // ----------------------------------------------------------------

   // Data counter and data signal, active from count zero.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_cnt_reg  <= 16'h0000;
         data_sig_reg <= 1'b1;
      end
      else if (srst || (ctrl_reg.counter_clear && tick))
      begin
         bit_cnt_reg  <= 16'h0000;
         data_sig_reg <= 1'b1;
      end
      else if (db_hit)
      begin
         bit_cnt_reg  <= 16'h0000;
         data_sig_reg <= !data_sig_reg;
      end
      else if (tick && running)
      begin
         bit_cnt_reg <= bit_cnt_reg + 16'h0001;
         if (ap_hit)
            data_sig_reg <= !data_sig_reg;
      end
   end

   // Carrier counter and carrier signal.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         carr_cnt_reg    <= 8'h00;
         carrier_sig_reg <= 1'b1;
      end
      else if (srst || (ctrl_reg.counter_clear && tick))
      begin
         carr_cnt_reg    <= 8'h00;
         carrier_sig_reg <= 1'b1;
      end
      else if (tick && running)
      begin
         if (carr_cnt_reg == carrier_reg.carrier_period)
         begin
            carr_cnt_reg    <= 8'h00;
            carrier_sig_reg <= !carrier_sig_reg;
         end
         else
         begin
            carr_cnt_reg <= carr_cnt_reg + 8'h01;
            if (carr_cnt_reg == carrier_reg.carrier_duty)
               carrier_sig_reg <= !carrier_sig_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Match flags; a hit in the clearing cycle keeps the flag set.
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active_flag_reg <= 1'b0;
         length_flag_reg <= 1'b0;
      end
      else if (srst)
      begin
         active_flag_reg <= 1'b0;
         length_flag_reg <= 1'b0;
      end
      else
      begin
         active_flag_reg <= ap_hit | (active_flag_reg & !(wr_flags & hwdata[IRC_FLAG_ACT_BIT]));
         length_flag_reg <= db_hit | (length_flag_reg & !(wr_flags & hwdata[IRC_FLAG_LEN_BIT]));
      end
   end

   // ----------------------------------------------------------------
   // Output pins and interrupt, each from a flip-flop.
   // ----------------------------------------------------------------
   assign tx_next  = (ctrl_reg.count_run & carrier_sig_reg & data_sig_reg) ^ ctrl_reg.output_invert;
   assign clp_next = ctrl_reg.count_run & !data_sig_reg;

   // Pins held inactive while stopped; the interrupt is not.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_reg  <= 1'b0;
         clp_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         tx_reg  <= tx_next;
         clp_reg <= clp_next;
         irq_reg <= (active_flag_reg & active_ie_reg) | (length_flag_reg & length_ie_reg);
      end
   end

   assign ir_transmit_output = tx_reg;
   assign clear_pulse_output = clp_reg;
   assign irq                = irq_reg;
   assign hrdata             = hrdata_reg;
   assign hreadyout          = hreadyout_reg;
   assign hresp              = 1'b0;

   // ----------------------------------------------------------------
   // Assertions and covers.
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   a_bit_wrap: assert property (db_hit && !srst |=> bit_cnt_reg == 16'h0000)
      else $error("data counter not zero after length match");
   a_oneshot_stop: assert property (db_hit && ctrl_reg.oneshot_select && !wr_ctrl |=> !ctrl_reg.count_run)
      else $error("one-shot did not stop");
   a_active_flag: assert property (ap_hit |=> active_flag_reg)
      else $error("active flag not set");
   a_length_flag: assert property (db_hit |=> length_flag_reg)
      else $error("length flag not set");
   a_irq_gate: assert property (irq |-> $past(active_flag_reg & active_ie_reg | length_flag_reg & length_ie_reg))
      else $error("interrupt without enabled flag");
   a_soft_reset: assert property (srst |=> !srst && !active_flag_reg && bit_cnt_reg == 16'h0000)
      else $error("soft reset incomplete");
   a_stop_idle: assert property (!ctrl_reg.count_run ##1 !ctrl_reg.count_run |=>
                                 tx_reg == $past(ctrl_reg.output_invert) && !clp_reg)
      else $error("outputs active while stopped");
   a_pend_xfer: assert property (db_hit && ctrl_reg.compare_buffer_enable && !wr_blen |=> !length_pend_reg)
      else $error("pending flag not cleared on transfer");
   a_carr_wrap: assert property (tick && running && carr_cnt_reg == carrier_reg.carrier_period |=>
                                 carr_cnt_reg == 8'h00 && carrier_sig_reg != $past(carrier_sig_reg))
      else $error("carrier did not wrap");
   a_read_wait: assert property (hready && hsel && htrans[1] && !hwrite && !rd_pend_reg |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   c_oneshot: cover property (db_hit && ctrl_reg.oneshot_select);
   c_buffered: cover property (db_hit && ctrl_reg.compare_buffer_enable && length_pend_reg);
   c_flag_clear: cover property (length_flag_reg ##1 !length_flag_reg);
   c_irq: cover property (irq);

endmodule : irc_unit
`default_nettype wire

// ---- irc_emitter_model.sv ----
// Emitter-side model: times each high run seen on the two output pins of the unit.
// Assumes it shares the core clock and reset with the unit that it watches.
`timescale 1ns/1ps
`default_nettype none
module irc_emitter_model
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Pins of the unit.
   input  wire logic        ir_transmit_output,
   input  wire logic        clear_pulse_output,
   // Run lengths, each with a one-cycle strobe.
   output logic             tx_done,
   output logic [15:0]      tx_len,
   output logic             cp_done,
   output logic [15:0]      cp_len
);
   logic [15:0] tx_cnt_reg;
   logic [15:0] cp_cnt_reg;

   // ----------------------------------------------------------------
   // Run timing
   // ----------------------------------------------------------------
   // Counts the cycles of a high run and reports its length when the pin falls.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_cnt_reg <= 16'h0;
         cp_cnt_reg <= 16'h0;
         tx_done    <= 1'b0;
         cp_done    <= 1'b0;
         tx_len     <= 16'h0;
         cp_len     <= 16'h0;
      end
      else
      begin
         tx_cnt_reg <= ir_transmit_output ? tx_cnt_reg + 16'h1 : 16'h0;
         cp_cnt_reg <= clear_pulse_output ? cp_cnt_reg + 16'h1 : 16'h0;
         tx_done    <= !ir_transmit_output && (tx_cnt_reg != 16'h0);
         cp_done    <= !clear_pulse_output && (cp_cnt_reg != 16'h0);
         tx_len     <= tx_cnt_reg;
         cp_len     <= cp_cnt_reg;
      end
   end
endmodule : irc_emitter_model
`default_nettype wire

// ---- testbench.sv ----
// Bench for the infrared waveform unit: AHB-Lite master, pin run timing, read notes.
// Assumes irc_pkg, irc_unit and irc_emitter_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import irc_pkg::*;
   ;
   logic        core_clk, rstn, hsel, hwrite, debug_mode, rd_dp;
   logic        hreadyout, hresp, tx, cp, irq, tx_done, cp_done;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr;
   logic [15:0] tx_len, cp_len, rnd;
   logic [15:0] txq[$], cpq[$];
   logic [31:0] hwdata, hrdata, rdn;
   logic [31:0] rdq[$];
   int          miscompares = 0, compares = 0;

   // Unit under test and the emitter model on its pins.
   irc_unit DUT
   (
      .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .debug_mode(debug_mode), .ir_transmit_output(tx), .clear_pulse_output(cp), .irq(irq)
   );
   irc_emitter_model emitter
   (
      .core_clk(core_clk), .rstn(rstn), .ir_transmit_output(tx), .clear_pulse_output(cp),
      .tx_done(tx_done), .tx_len(tx_len), .cp_done(cp_done), .cp_len(cp_len)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
   begin
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask : chk

   // One single-word transfer; a read notes its expected low half and mask.
   task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [15:0] m);
   begin
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      htrans <= 2'h0;
      rd_dp  <= !w;
      if (w) hwdata <= {16'h0, d};
      else rdq.push_back({m, d});
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd_dp  <= 1'b0;
   end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(a, 1'b1, d, 16'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      bus(a, 1'b0, e, m);
   endtask : rd

   // Clears both counters, starts counting, then lets n cycles pass.
   task automatic run(input logic [15:0] c, input int n);
   begin
      wr(8'h04, c | 16'h200);
      wr(8'h04, c | 16'h100);
      repeat (n) @(posedge core_clk);
   end
   endtask : run

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
   begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask : results

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // ----------------------------------------------------------------
   // Clock, watcher and watchdog
   // ----------------------------------------------------------------
   always #25 core_clk = ~core_clk;

   // Takes the oldest note whenever read data or a pin run appears.
   always @(posedge core_clk)
   begin
      if (rd_dp === 1'b1 && hreadyout === 1'b1 && rdq.size() > 0)
      begin
         rdn = rdq.pop_front();
         chk(hrdata & {16'hFFFF, rdn[31:16]}, {16'h0, rdn[15:0]}, "hrdata");
         chk({31'h0, hresp}, 32'h0, "hresp");
      end
      if (tx_done === 1'b1 && txq.size() > 0)
         chk({16'h0, tx_len}, {16'h0, txq.pop_front()}, "transmit run");
      if (cp_done === 1'b1 && cpq.size() > 0)
         chk({16'h0, cp_len}, {16'h0, cpq.pop_front()}, "clear pulse run");
   end

   // Cuts a hang short; the whole sequence needs well under 2000 cycles.
   initial
   begin
      #100000;
      miscompares++;
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk   = 1'b0;
      rstn       = 1'b0;
      hsel       = 1'b1;
      hwrite     = 1'b0;
      htrans     = 2'h0;
      hsize      = 3'h2;
      haddr      = 8'h0;
      hwdata     = 32'h0;
      debug_mode = 1'b0;
      rd_dp      = 1'b0;
      rnd        = 16'h42;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      // Register defaults, reserved bits and an unmapped place.
      rd(8'h00, 16'h0, 16'hFFFF);
      rd(8'h20, 16'h0, 16'hFFFF);
      wr(8'h00, 16'hFFFF);
      rd(8'h00, 16'h1F3, 16'hFFFF);
      wr(8'h00, 16'h0);
      wr(8'h04, 16'h1);
      repeat (3)
      begin
         rnd = lfsr(rnd);
         wr(8'h10, rnd);
         rd(8'h10, rnd, 16'hFFFF);
      end
      // Repeat mode, one tick per cycle: carrier 3/1, bit 11, active 5.
      wr(8'h0C, 16'h5);
      wr(8'h10, 16'hB);
      wr(8'h14, 16'h301);
      repeat (3)
      begin
         txq.push_back(16'h2);
         txq.push_back(16'h2);
         cpq.push_back(16'h6);
      end
      run(16'h1, 80);
      rd(8'h04, 16'h101, 16'hFFFF);
      rd(8'h18, 16'h3, 16'h3);
      wr(8'h1C, 16'h2);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1, "irq");
      wr(8'h04, 16'h1);
      repeat (3) @(posedge core_clk);
      chk({30'h0, tx, cp}, 32'h0, "stopped pins");
      wr(8'h18, 16'h2);
      rd(8'h18, 16'h1, 16'h3);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq");
      // Buffered lengths, divide by two: the first bit keeps the old lengths.
      wr(8'h04, 16'h0);
      wr(8'h00, 16'h10);
      wr(8'h04, 16'h9);
      wr(8'h0C, 16'h3);
      wr(8'h10, 16'hB);
      rd(8'h18, 16'hC, 16'hC);
      cpq = '{16'hC, 16'h10, 16'h10};
      txq = '{16'h4, 16'h4, 16'h4, 16'h4};
      // Start lands on a tick edge, so the first carrier state lasts two whole ticks.
      @(posedge core_clk);
      run(16'h9, 100);
      rd(8'h18, 16'h0, 16'hC);
      // One-shot bit, frozen for a while by debug mode.
      run(16'h5, 4);
      debug_mode <= 1'b1;
      repeat (60) @(posedge core_clk);
      rd(8'h04, 16'h105, 16'hFFFF);
      debug_mode <= 1'b0;
      repeat (60) @(posedge core_clk);
      rd(8'h04, 16'h5, 16'hFFFF);
      // Inverted idle level, then a soft reset.
      wr(8'h04, 16'h15);
      repeat (3) @(posedge core_clk);
      chk({31'h0, tx}, 32'h1, "idle transmit");
      wr(8'h04, 16'h17);
      rd(8'h18, 16'h0, 16'h3);
      rd(8'h04, 16'h15, 16'hFFFF);
      rd(8'h08, 16'h0, 16'hFFFF);
      repeat (3) @(posedge core_clk);
      chk(32'(txq.size() + cpq.size() + rdq.size()), 32'h0, "notes left");
      results();
   end
endmodule : testbench
`default_nettype wire
